// *** hw/bypass_cfg.svh ***
// Purpose: Constants for the bypass switchover sequencer.
// Assumes: pclk at 20 MHz; times are held in units of 0.1 s.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
`ifndef BYPASS_CFG_SVH
`define BYPASS_CFG_SVH
// ==================================================================
// Timebase
`define CLK_HZ 20000000
`define TENTH_S_MS 100
`define TENTH_CYCLES ((`CLK_HZ / 1000) * `TENTH_S_MS)
`define TENTH_W 21
// ==================================================================
// Register offsets
`define OFS_CTRL 12'h000
`define OFS_ILOCK 12'h004
`define OFS_SWAIT 12'h008
`define OFS_SWFREQ 12'h00C
`define OFS_FREQ 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ 12'h018
`define OFS_MASK 12'h01C
`define OFS_STATE 12'h020
// ==================================================================
// Fields and reset values
`define CTRL_SEQ_EN 0
`define CTRL_FAULT_BYP 1
`define ILOCK_RESET 10'h00A
`define SWAIT_RESET 10'h005
`define TIME_MAX 10'h3E8
`define SWFREQ_OFF 14'h270F
`define SWFREQ_MAX 14'h0258
`define IRQ_W 4
`define IRQ_TO_BYPASS 0
`define IRQ_TO_INV 1
`define IRQ_FAULT 2
`define IRQ_STOP 3
`endif

// *** hw/bypass_pkg.sv ***
// Purpose: Types for the bypass switchover sequencer.
// Assumes: Field widths are written out here; no configuration header is included.
// Notes: One packed struct holds the whole module state.
package bypass_pkg;
  typedef enum logic [2:0] {
    st_idle, st_inv_close, st_inv_wait, st_inv_run, st_ilock_to_byp, st_bypass,
    st_ilock_to_inv, st_stopped
  } seq_state_t;

  typedef struct packed {
    logic input_contactor;
    logic bypass_contactor;
    logic inverter_output_contactor;
    logic inverter_run;
  } contactor_out_t;

  typedef struct packed {
    seq_state_t state;
    contactor_out_t out;
    logic sequence_enable_setting;
    logic fault_bypass_setting;
    logic [9:0] interlock_time_setting;
    logic [9:0] start_wait_setting;
    logic [13:0] switchover_frequency_setting;
    logic [20:0] tick_cnt;
    logic [9:0] tenths;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] start_s;
    logic [1:0] stop_s;
    logic [1:0] auto_s;
    logic [1:0] fault_s;
    logic [1:0] thermal_s;
    logic [1:0] cpu_s;
  } seq_reg_t;
endpackage

// *** hw/bypass_switchover_sequencer.sv ***
// Purpose: Switches a motor between inverter drive and mains bypass.
// Assumes: Pins start, stop, auto select and faults are asynchronous levels.
// Notes: Output frequency arrives from the inverter core in 0.1 Hz units.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "bypass_cfg.svh"
module bypass_switchover_sequencer
  import bypass_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic auto_switch_select,
  input wire logic inverter_fault,
  input wire logic thermal_relay_trip,
  input wire logic cpu_fault,
  input wire logic [13:0] output_frequency,
  output logic input_contactor,
  output logic bypass_contactor,
  output logic inverter_output_contactor,
  output logic inverter_run,
  output logic irq
);

  seq_reg_t r;
  seq_reg_t next_r;
  logic tick;
  logic wr;
  logic rd;
  logic [3:0] ev;

  // ==================================================================
  // Helpers

  // Clamps a written time to the 0 to 100 s range in tenths.
  function automatic logic [9:0] clamp_time(input logic [31:0] v);
    if (v > {22'h000000, `TIME_MAX}) begin
      clamp_time = `TIME_MAX;
    end else begin
      clamp_time = v[9:0];
    end
  endfunction

  // Threshold crossed only when the feature is on; 9999 means off.
  function automatic logic freq_reached(input logic [13:0] thr, input logic [13:0] f);
    freq_reached = (thr != `SWFREQ_OFF) && (f >= thr);
  endfunction

  assign tick = (r.tick_cnt == `TENTH_W'(`TENTH_CYCLES - 1));
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // ==================================================================
  // Next state
  always_comb begin
    next_r = r;
    ev = 4'h0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // Only the second synchroniser stage is ever read below.
    next_r.start_s = {r.start_s[0], start_cmd};
    next_r.stop_s = {r.stop_s[0], stop_cmd};
    next_r.auto_s = {r.auto_s[0], auto_switch_select};
    next_r.fault_s = {r.fault_s[0], inverter_fault};
    next_r.thermal_s = {r.thermal_s[0], thermal_relay_trip};
    next_r.cpu_s = {r.cpu_s[0], cpu_fault};
    next_r.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;
    if (tick && r.tenths != 10'h000) begin
      next_r.tenths = r.tenths - 1'b1;
    end

    // Sequencer: contactor outputs follow the state.
    case (r.state)
      st_idle: begin
        if (r.sequence_enable_setting && r.start_s[1] && !r.stop_s[1]) begin
          next_r.state = st_inv_close;
        end
      end
      st_inv_close: begin
        next_r.tenths = r.start_wait_setting;
        next_r.state = st_inv_wait;
      end
      st_inv_wait: begin
        if (r.tenths == 10'h000) begin
          next_r.state = st_inv_run;
          ev[`IRQ_TO_INV] = 1'b1;
        end
      end
      st_inv_run: begin
        if (r.auto_s[1] && freq_reached(r.switchover_frequency_setting, output_frequency)) begin
          next_r.tenths = r.interlock_time_setting;
          next_r.state = st_ilock_to_byp;
        end
      end
      st_ilock_to_byp: begin
        if (r.tenths == 10'h000) begin
          next_r.state = st_bypass;
          ev[`IRQ_TO_BYPASS] = 1'b1;
        end
      end
      st_bypass: begin
        // Dropping the start command hands the motor back to the inverter.
        if (!r.start_s[1] && !r.fault_s[1]) begin
          next_r.tenths = r.interlock_time_setting;
          next_r.state = st_ilock_to_inv;
        end
      end
      st_ilock_to_inv: begin
        if (r.tenths == 10'h000) begin
          next_r.state = st_inv_close;
        end
      end
      st_stopped: begin
        if (!r.fault_s[1] && !r.thermal_s[1] && !r.cpu_s[1] && !r.start_s[1]) begin
          next_r.state = st_idle;
        end
      end
      default: begin
        next_r.state = st_idle;
      end
    endcase

    // Stop and faults override the normal sequence.
    if (!r.sequence_enable_setting || r.stop_s[1]) begin
      if (r.state != st_idle) begin
        ev[`IRQ_STOP] = 1'b1;
      end
      next_r.state = st_idle;
    end else if (r.thermal_s[1] || r.cpu_s[1]) begin
      if (r.state != st_stopped) begin
        ev[`IRQ_FAULT] = 1'b1;
      end
      next_r.state = st_stopped;
    end else if (r.fault_s[1] && r.state != st_stopped && r.state != st_bypass
                 && r.state != st_ilock_to_byp && r.state != st_idle) begin
      ev[`IRQ_FAULT] = 1'b1;
      if (r.fault_bypass_setting) begin
        next_r.tenths = r.interlock_time_setting;
        next_r.state = st_ilock_to_byp;
      end else begin
        next_r.state = st_stopped;
      end
    end

    // Outputs decoded from the next state so they leave a flip-flop.
    next_r.out = '0;
    case (next_r.state)
      st_inv_close, st_inv_wait: begin
        next_r.out.input_contactor = 1'b1;
        next_r.out.inverter_output_contactor = 1'b1;
      end
      st_inv_run: begin
        next_r.out.input_contactor = 1'b1;
        next_r.out.inverter_output_contactor = 1'b1;
        next_r.out.inverter_run = 1'b1;
      end
      st_ilock_to_byp, st_ilock_to_inv, st_idle: begin
        next_r.out.input_contactor = r.sequence_enable_setting;
      end
      st_bypass: begin
        next_r.out.input_contactor = !r.fault_s[1];
        next_r.out.bypass_contactor = 1'b1;
      end
      default: begin
        next_r.out = '0;
      end
    endcase

    // APB reads and writes; zero-wait slave, unmapped addresses answer with pslverr.
    if (psel && !penable) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h00000000;
      if (paddr == `OFS_CTRL) begin
        next_r.prdata = {30'h00000000, r.fault_bypass_setting, r.sequence_enable_setting};
      end else if (paddr == `OFS_ILOCK) begin
        next_r.prdata = {22'h000000, r.interlock_time_setting};
      end else if (paddr == `OFS_SWAIT) begin
        next_r.prdata = {22'h000000, r.start_wait_setting};
      end else if (paddr == `OFS_SWFREQ) begin
        next_r.prdata = {18'h00000, r.switchover_frequency_setting};
      end else if (paddr == `OFS_FREQ) begin
        next_r.prdata = {18'h00000, output_frequency};
      end else if (paddr == `OFS_STATUS) begin
        next_r.prdata = {28'h0000000, r.out};
      end else if (paddr == `OFS_IRQ) begin
        next_r.prdata = {28'h0000000, r.irq_status};
      end else if (paddr == `OFS_MASK) begin
        next_r.prdata = {28'h0000000, r.irq_mask};
      end else if (paddr == `OFS_STATE) begin
        next_r.prdata = {29'h00000000, r.state};
      end else begin
        next_r.pslverr = 1'b1;
      end
    end
    if (wr && r.pready) begin
      if (paddr == `OFS_CTRL) begin
        next_r.sequence_enable_setting = pwdata[`CTRL_SEQ_EN];
        next_r.fault_bypass_setting = pwdata[`CTRL_FAULT_BYP];
      end else if (paddr == `OFS_ILOCK) begin
        next_r.interlock_time_setting = clamp_time(pwdata);
      end else if (paddr == `OFS_SWAIT) begin
        next_r.start_wait_setting = clamp_time(pwdata);
      end else if (paddr == `OFS_SWFREQ) begin
        if (pwdata[13:0] <= `SWFREQ_MAX || pwdata[13:0] == `SWFREQ_OFF) begin
          next_r.switchover_frequency_setting = pwdata[13:0];
        end
      end else if (paddr == `OFS_IRQ) begin
        next_r.irq_status = r.irq_status & ~pwdata[3:0];
      end else if (paddr == `OFS_MASK) begin
        next_r.irq_mask = pwdata[3:0];
      end
    end
    if (rd) begin
      next_r.prdata = r.prdata;
    end
    // Setting after clearing keeps an event that lands on a clear.
    next_r.irq_status = next_r.irq_status | ev;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  // ==================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= st_idle;
      r.interlock_time_setting <= `ILOCK_RESET;
      r.start_wait_setting <= `SWAIT_RESET;
      r.switchover_frequency_setting <= `SWFREQ_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign input_contactor = r.out.input_contactor;
  assign bypass_contactor = r.out.bypass_contactor;
  assign inverter_output_contactor = r.out.inverter_output_contactor;
  assign inverter_run = r.out.inverter_run;
  assign irq = r.irq;

endmodule

// *** tb/motor_drive_model.sv ***
// Purpose: Inverter core and motor that feed output frequency back.
// Assumes: Frequency is in 0.1 Hz units.
// Notes: Contactors are taken to close at once.
`timescale 1ns/100ps
module motor_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic inverter_run,
  input wire logic inverter_output_contactor,
  output logic [13:0] output_frequency
);
  // ==========
  // Ramp
  // The motor spins up only while driven through a closed contactor.
  // Closing is instant, so even a start wait of zero outlasts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_frequency <= 14'h0000;
    end else if (inverter_run && inverter_output_contactor) begin
      if (output_frequency < 14'h0258) begin
        output_frequency <= output_frequency + 14'h0014;
      end
    end else begin
      output_frequency <= 14'h0000;
    end
  end
endmodule

// *** tb/bypass_switchover_sequencer_assertions.sv ***
// Purpose: Port-level checks of the bypass switchover sequencer.
// Assumes: Inputs pass two sync stages before acting.
// Notes: Bound into the sequencer below.
`timescale 1ns/100ps
module bypass_sequencer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_cmd,
  input wire logic thermal_relay_trip,
  input wire logic cpu_fault,
  input wire logic bypass_contactor,
  input wire logic inverter_output_contactor,
  input wire logic inverter_run
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Contactors
  // Six cycles leave room for the sync stages and the output register.
  a_contactor_excl: assert property (!(bypass_contactor && inverter_output_contactor))
    else $error("both motor contactors closed");
  a_run_after_close: assert property ($rose(inverter_run) |-> $past(inverter_output_contactor))
    else $error("inverter started before its contactor");
  a_bypass_gap: assert property ($rose(bypass_contactor) |-> !$past(inverter_output_contactor))
    else $error("bypass closed without interlock gap");
  a_stop_opens: assert property (stop_cmd [*6] |-> !inverter_run && !bypass_contactor)
    else $error("stop left motor driven");
  a_trip_no_bypass: assert property ((thermal_relay_trip || cpu_fault) [*6] |-> !bypass_contactor)
    else $error("bypass taken on trip");
  // ==========
  // Register bus and cover points
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  c_bypass: cover property ($rose(bypass_contactor));
  c_run: cover property ($rose(inverter_run));
  c_err: cover property (pslverr);
endmodule
bind bypass_switchover_sequencer bypass_sequencer_checker bypass_sequencer_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .stop_cmd(stop_cmd), .thermal_relay_trip(thermal_relay_trip),
  .cpu_fault(cpu_fault), .bypass_contactor(bypass_contactor),
  .inverter_output_contactor(inverter_output_contactor), .inverter_run(inverter_run));

// *** tb/bypass_switchover_sequencer_bench.sv ***
// Purpose: Self-checking bench for the bypass switchover sequencer.
// Assumes: Times set to zero tenths keep every sequence short.
// Notes: Default times are checked only as register values.
`timescale 1ns/100ps
`include "bypass_cfg.svh"
module bypass_switchover_sequencer_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq;
  logic start_cmd = 1'b0, stop_cmd = 1'b0, auto_switch_select = 1'b0;
  logic inverter_fault = 1'b0, thermal_relay_trip = 1'b0, cpu_fault = 1'b0;
  logic [13:0] output_frequency;
  logic input_contactor, bypass_contactor, inverter_output_contactor, inverter_run;
  logic [3:0] outs;
  int n_fail = 0;
  int n_tests = 0;
  assign outs = {input_contactor, bypass_contactor, inverter_output_contactor, inverter_run};
  bypass_switchover_sequencer bypass_switchover_sequencer_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_cmd, .stop_cmd,
    .auto_switch_select, .inverter_fault, .thermal_relay_trip, .cpu_fault,
    .output_frequency, .input_contactor, .bypass_contactor, .inverter_output_contactor,
    .inverter_run, .irq);
  motor_drive_model motor_drive_model_i (.pclk, .presetn, .inverter_run,
    .inverter_output_contactor, .output_frequency);
  // ==========
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request is held until ready is sampled high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pins in order start, stop, auto select, fault, thermal trip, cpu fault.
  task automatic drive(input logic [5:0] v);
    @(posedge pclk);
    {start_cmd, stop_cmd, auto_switch_select, inverter_fault, thermal_relay_trip, cpu_fault} <= v;
  endtask
  task automatic wait_out(input int b, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (outs[b] !== v && n < 300);
    check({31'h0, outs[b]}, {31'h0, v});
  endtask
  task automatic settle(input logic [5:0] v);
    drive(v);
    repeat (30) @(posedge pclk);
    #1;
  endtask
  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // Clock, watchdog and tests
  initial begin
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({27'h0, outs, irq}, 32'h0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `OFS_ILOCK, 32'h0);
    check(rd, 32'h0000000A);
    apb(1'b0, `OFS_SWAIT, 32'h0);
    check(rd, 32'h00000005);
    apb(1'b0, `OFS_SWFREQ, 32'h0);
    check(rd, 32'h0000270F);
    apb(1'b0, 12'h024, 32'h0);
    check({rd[31:1], err}, 32'h1);
    apb(1'b1, `OFS_ILOCK, 32'h00001000);
    apb(1'b0, `OFS_ILOCK, 32'h0);
    check(rd, 32'h000003E8);
    apb(1'b1, `OFS_ILOCK, 32'h0);
    apb(1'b1, `OFS_SWAIT, 32'h0);
    apb(1'b1, `OFS_MASK, 32'hF);
    settle(6'h20);
    check({28'h0, outs}, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h1);
    wait_out(0, 1'b1);
    check({27'h0, outs, irq}, 32'h17);
    apb(1'b1, `OFS_IRQ, 32'hF);
    apb(1'b1, `OFS_MASK, 32'h0);
    // With the threshold off, auto select must leave the motor on the inverter.
    settle(6'h28);
    check({28'h0, outs}, 32'hB);
    apb(1'b1, `OFS_SWFREQ, 32'h0000012C);
    drive(6'h28);
    wait_out(2, 1'b1);
    check({27'h0, outs, irq}, 32'h18);
    apb(1'b0, `OFS_IRQ, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rd, 32'h0000000C);
    apb(1'b0, `OFS_FREQ, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `OFS_SWFREQ, 32'h00000259);
    apb(1'b0, `OFS_SWFREQ, 32'h0);
    check(rd, 32'h0000012C);
    apb(1'b1, `OFS_MASK, 32'h1);
    // The mask lands at the access edge, so irq is looked at once it has settled.
    #1;
    check({31'h0, irq}, 32'h1);
    settle(6'h10);
    check({28'h0, outs}, 32'h8);
    apb(1'b1, `OFS_CTRL, 32'h3);
    settle(6'h00);
    drive(6'h20);
    wait_out(0, 1'b1);
    drive(6'h24);
    wait_out(2, 1'b1);
    settle(6'h10);
    for (int i = 0; i < 2; i++) begin
      settle(6'h00);
      drive(6'h20);
      wait_out(0, 1'b1);
      settle(i == 0 ? 6'h22 : 6'h21);
      check({28'h0, outs}, 32'h0);
      settle(6'h10);
    end
    apb(1'b1, `OFS_CTRL, 32'h1);
    settle(6'h00);
    drive(6'h20);
    wait_out(0, 1'b1);
    settle(6'h24);
    check({29'h0, outs[2:0]}, 32'h0);
    end_sim;
  end
endmodule
